// *** src/scmc_channel_regs.sv ***
// Purpose: One channel's configuration registers and field decode
// Assumes: Synchronous byte writes, writable masks from the top
// Notes:   Fixed bits are forced, never stored
`timescale 1ns/1ns
`default_nettype none
`include "scmc_params.svh"

module scmc_channel_regs #(
  parameter logic [7:0] MODE_WM = `SCMC_MODE_LOW_WM_CH0,
  parameter logic [7:0] COMM_WM = `SCMC_COMM_LOW_WM_CH0
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               wr_mode_low,
  input  wire logic               wr_comm_low,
  input  wire logic               wr_comm_high,
  input  wire logic [7:0]         wdata,
  output var  scmc_pkg::scmc_regs_t regs,
  output var  scmc_pkg::scmc_cfg_t  cfg
);

  logic [7:0] mode_low_reg;
  logic [7:0] comm_low_reg;
  logic [7:0] comm_high_reg;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_low_reg  <= `SCMC_MODE_LOW_RST & MODE_WM;
      comm_low_reg  <= `SCMC_COMM_LOW_RST & COMM_WM;
      comm_high_reg <= `SCMC_COMM_HIGH_RST;
    end
    else
    begin
      // Each byte has its own strobe
      if (wr_mode_low)
        mode_low_reg <= wdata & MODE_WM;
      if (wr_comm_low)
        comm_low_reg <= wdata & COMM_WM;
      if (wr_comm_high)
        comm_high_reg <= wdata & `SCMC_COMM_HIGH_WM;
    end
  end

  always_comb
  begin
    regs.mode_low  = mode_low_reg | `SCMC_MODE_LOW_FIX1;
    regs.comm_low  = comm_low_reg | `SCMC_COMM_LOW_FIX1;
    regs.comm_high = comm_high_reg;
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  always_comb
  begin
    cfg.uart_mode       = mode_low_reg[`SCMC_B_PROTO];
    cfg.buf_empty_irq   = mode_low_reg[`SCMC_B_IRQ_SRC];
    // Inversion only means something in UART mode
    cfg.rx_level_invert = mode_low_reg[`SCMC_B_RX_INV]
                          & mode_low_reg[`SCMC_B_PROTO];
    unique case ({comm_high_reg[`SCMC_B_TXE], comm_high_reg[`SCMC_B_RXE]})
      2'b00:   cfg.xfer = scmc_pkg::SCMC_XFER_OFF;
      2'b01:   cfg.xfer = scmc_pkg::SCMC_XFER_RX;
      2'b10:   cfg.xfer = scmc_pkg::SCMC_XFER_TX;
      2'b11:   cfg.xfer = scmc_pkg::SCMC_XFER_TRX;
    endcase
    // Type 1..4 from data phase and polarity
    cfg.phase_type = {1'b0, comm_high_reg[`SCMC_B_DAP], comm_high_reg[`SCMC_B_CKP]}
                     + 3'd1;
    cfg.error_irq_enable = comm_high_reg[`SCMC_B_EOC];
    unique case (comm_high_reg[`SCMC_B_PTC_H:`SCMC_B_PTC_L])
      2'b00:   cfg.parity = scmc_pkg::SCMC_PAR_NONE;
      2'b01:   cfg.parity = scmc_pkg::SCMC_PAR_ZERO;
      2'b10:   cfg.parity = scmc_pkg::SCMC_PAR_EVEN;
      2'b11:   cfg.parity = scmc_pkg::SCMC_PAR_ODD;
    endcase
    cfg.lsb_first    = comm_low_reg[`SCMC_B_DIR];
    cfg.stop_bits    = comm_low_reg[`SCMC_B_SLC_H:`SCMC_B_SLC_L];
    cfg.stop_illegal = &comm_low_reg[`SCMC_B_SLC_H:`SCMC_B_SLC_L];
    cfg.data_8bit    = comm_low_reg[`SCMC_B_DLS];
  end

endmodule
`default_nettype wire

// *** src/scmc_params.svh ***
// Purpose: Constants for the serial channel mode configuration bank
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   Definitions only
`ifndef SCMC_PARAMS_SVH
`define SCMC_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SCMC_ADDR_W           20
`define SCMC_MODE_LOW_CH0     20'hf_0110
`define SCMC_MODE_LOW_CH1     20'hf_0112
`define SCMC_COMM_LOW_CH0     20'hf_0118
`define SCMC_COMM_HIGH_CH0    20'hf_0119
`define SCMC_COMM_LOW_CH1     20'hf_011a
`define SCMC_COMM_HIGH_CH1    20'hf_011b

// ----------------------------------------
// Reset values and fixed-bit masks
// ----------------------------------------
`define SCMC_MODE_LOW_RST     8'h20
`define SCMC_COMM_LOW_RST     8'h87
`define SCMC_COMM_HIGH_RST    8'h00
`define SCMC_MODE_LOW_FIX1    8'h20
`define SCMC_COMM_LOW_FIX1    8'h06
// Writable masks per channel; high setting byte mask shared by both
`define SCMC_MODE_LOW_WM_CH0  8'h03
`define SCMC_MODE_LOW_WM_CH1  8'h43
`define SCMC_COMM_LOW_WM_CH0  8'hb1
`define SCMC_COMM_LOW_WM_CH1  8'h91
`define SCMC_COMM_HIGH_WM     8'hf7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCMC_B_RX_INV         6
`define SCMC_B_PROTO          1
`define SCMC_B_IRQ_SRC        0
`define SCMC_B_TXE            7
`define SCMC_B_RXE            6
`define SCMC_B_DAP            5
`define SCMC_B_CKP            4
`define SCMC_B_EOC            2
`define SCMC_B_PTC_H          1
`define SCMC_B_PTC_L          0
`define SCMC_B_DIR            7
`define SCMC_B_SLC_H          5
`define SCMC_B_SLC_L          4
`define SCMC_B_DLS            0

`endif

// *** src/scmc_pkg.sv ***
// Purpose: Types for the serial channel mode configuration bank
// Assumes: Constants live in scmc_params.svh
// Notes:   Decoded per-channel configuration travels as one struct
package scmc_pkg;

  typedef enum logic [3:0] {
    SCMC_XFER_OFF  = 4'b0001,
    SCMC_XFER_RX   = 4'b0010,
    SCMC_XFER_TX   = 4'b0100,
    SCMC_XFER_TRX  = 4'b1000
  } scmc_xfer_t;

  typedef enum logic [3:0] {
    SCMC_PAR_NONE  = 4'b0001,
    SCMC_PAR_ZERO  = 4'b0010,
    SCMC_PAR_EVEN  = 4'b0100,
    SCMC_PAR_ODD   = 4'b1000
  } scmc_parity_t;

  typedef struct packed {
    logic         uart_mode;
    logic         buf_empty_irq;
    logic         rx_level_invert;
    scmc_xfer_t   xfer;
    logic [2:0]   phase_type;
    logic         error_irq_enable;
    scmc_parity_t parity;
    logic         lsb_first;
    logic [1:0]   stop_bits;
    logic         stop_illegal;
    logic         data_8bit;
  } scmc_cfg_t;

  typedef struct packed {
    logic [7:0] mode_low;
    logic [7:0] comm_low;
    logic [7:0] comm_high;
  } scmc_regs_t;

endpackage

// *** src/scmc_top.sv ***
// Purpose: Two-channel serial mode and communication setting registers
// Assumes: 8-bit synchronous register port, one access per cycle
// Notes:   Outputs feed the shift engine and interrupt routing
//
// How it works
// - Protocol select bit: 0 clocked synchronous, 1 UART.
// - Interrupt source: 0 transfer end, 1 buffer empty on buffer-to-shift move.
// - UART receive inversion: 0 falling start edge as is, 1 rising edge inverted.
// - Receive inversion bit exists at bit 6 of channel 1 only.
// - Mode low resets to 20H; bit 5 fixed 1, other undefined bits 0.
// - Communication setting resets high byte 00H, low byte 87H.
// - Setting bytes written by single 8-bit accesses, each byte addressed.
// - Transmit/receive enables: off, receive, transmit, both.
// - Data phase and polarity pick one of four synchronous phase types.
// - Error enable 0 masks error irq; 1 raises it and masks receive end.
// - Low setting bits 2 and 1 fixed 1; other undefined bits 0.
// - Upper stop-bit select exists on channel 0 only.
// - Parity: none, zero bit unchecked, even, odd.
// - Bit order: 0 MSB first, 1 LSB first.
// - Stop bits: none, one, two on channel 0, 11 prohibited.
// - Data length: 0 seven bits, 1 eight bits.
`timescale 1ns/1ns
`default_nettype none
`include "scmc_params.svh"

module scmc_top #(
  parameter int NCH = 2
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic [`SCMC_ADDR_W-1:0]     reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic [NCH-1:0]              channel_running_flag,
  input  wire logic [NCH-1:0]              rx_error_event,
  input  wire logic [NCH-1:0]              rx_done_event,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_rvalid,
  output scmc_pkg::scmc_cfg_t [NCH-1:0]    chan_cfg,
  output logic      [NCH-1:0]              error_interrupt,
  output logic      [NCH-1:0]              receive_end_interrupt,
  output logic      [NCH-1:0]              cfg_write_while_running
);

  scmc_pkg::scmc_regs_t [NCH-1:0] regs;
  scmc_pkg::scmc_cfg_t  [NCH-1:0] cfg;
  logic [7:0]                     rdata_next;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [`SCMC_ADDR_W-1:0] a,
                               input logic [`SCMC_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  function automatic logic [`SCMC_ADDR_W-1:0] addr_of(input int ch, input int kind);
    logic [`SCMC_ADDR_W-1:0] base;
    base = `SCMC_MODE_LOW_CH0;
    unique case (kind)
      0:       base = (ch == 0) ? `SCMC_MODE_LOW_CH0  : `SCMC_MODE_LOW_CH1;
      1:       base = (ch == 0) ? `SCMC_COMM_LOW_CH0  : `SCMC_COMM_LOW_CH1;
      default: base = (ch == 0) ? `SCMC_COMM_HIGH_CH0 : `SCMC_COMM_HIGH_CH1;
    endcase
    addr_of = base;
  endfunction

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : gen_ch
      logic wr_ml;
      logic wr_cl;
      logic wr_ch;
      assign wr_ml = reg_wr && hit(reg_addr, addr_of(g, 0));
      assign wr_cl = reg_wr && hit(reg_addr, addr_of(g, 1));
      assign wr_ch = reg_wr && hit(reg_addr, addr_of(g, 2));

      scmc_channel_regs #(
        .MODE_WM ((g == 1) ? `SCMC_MODE_LOW_WM_CH1 : `SCMC_MODE_LOW_WM_CH0),
        .COMM_WM ((g == 0) ? `SCMC_COMM_LOW_WM_CH0 : `SCMC_COMM_LOW_WM_CH1)
      ) u_regs (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .wr_mode_low  (wr_ml),
        .wr_comm_low  (wr_cl),
        .wr_comm_high (wr_ch),
        .wdata        (reg_wdata),
        .regs         (regs[g]),
        .cfg          (cfg[g])
      );

      // Flags a software slip; the write still lands
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          cfg_write_while_running[g] <= 1'b0;
        else
          cfg_write_while_running[g] <= (wr_cl | wr_ch) & channel_running_flag[g];
      end

      // Error routing: enable steals receive end on errored frames
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          error_interrupt[g]       <= 1'b0;
          receive_end_interrupt[g] <= 1'b0;
        end
        else
        begin
          error_interrupt[g]       <= rx_error_event[g] & cfg[g].error_irq_enable;
          receive_end_interrupt[g] <= rx_done_event[g]
                                      & ~(rx_error_event[g] & cfg[g].error_irq_enable);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      chan_cfg <= '0;
    else
      chan_cfg <= cfg;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped addresses read zero; reads change nothing
  always_comb
  begin
    rdata_next = 8'h00;
    for (int c = 0; c < NCH; c++)
    begin
      if (hit(reg_addr, addr_of(c, 0)))
        rdata_next = regs[c].mode_low;
      if (hit(reg_addr, addr_of(c, 1)))
        rdata_next = regs[c].comm_low;
      if (hit(reg_addr, addr_of(c, 2)))
        rdata_next = regs[c].comm_high;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_next;
    end
  end

endmodule
`default_nettype wire

// *** test/scmc_checker.sv ***
// Purpose: Port checker for the serial channel configuration bank
// Assumes: Channel 0 watched for routing, flag and decode
// Notes:   Decoded config lags its register by one cycle
`timescale 1ns/1ns
`default_nettype none
`include "scmc_params.svh"
module scmc_checker #(
  parameter int NCH = 2
) (
  input wire logic                     core_clk,
  input wire logic                     rst_n,
  input wire logic [`SCMC_ADDR_W-1:0]  reg_addr,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_wdata,
  input wire logic [NCH-1:0]           channel_running_flag,
  input wire logic [NCH-1:0]           rx_error_event,
  input wire logic [NCH-1:0]           rx_done_event,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     reg_rvalid,
  input wire scmc_pkg::scmc_cfg_t [NCH-1:0] chan_cfg,
  input wire logic [NCH-1:0]           error_interrupt,
  input wire logic [NCH-1:0]           receive_end_interrupt,
  input wire logic [NCH-1:0]           cfg_write_while_running
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_trx_wr;
    reg_wr && reg_addr == `SCMC_COMM_HIGH_CH0 && reg_wdata[7:6] == 2'h3;
  endsequence
  sequence s_cfg_trx;
    ##2 chan_cfg[0].xfer == scmc_pkg::SCMC_XFER_TRX;
  endsequence
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rd_origin: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without read");
  a_err_route: assert property (rx_error_event[0] && rx_done_event[0]
    && chan_cfg[0].error_irq_enable |=> error_interrupt[0] && !receive_end_interrupt[0])
    else $error("errored frame routed wrong");
  a_err_masked: assert property (rx_error_event[0] && !chan_cfg[0].error_irq_enable
    |=> !error_interrupt[0])
    else $error("masked error raised");
  a_end_clean: assert property (rx_done_event[0] && !rx_error_event[0]
    |=> receive_end_interrupt[0] && !error_interrupt[0])
    else $error("clean frame not reported");
  a_run_flag: assert property (reg_wr && channel_running_flag[0]
    && reg_addr == `SCMC_COMM_LOW_CH0 |=> cfg_write_while_running[0])
    else $error("write while running not flagged");
  a_trx_decode: assert property (s_trx_wr |-> s_cfg_trx)
    else $error("transmit receive not decoded");
endmodule
`default_nettype wire

// *** test/scmc_peer.sv ***
// Purpose: Serial peer that ends receptions on request
// Assumes: One frame in flight
// Notes:   Slow frames take eight cycles longer than fast ones
`timescale 1ns/1ns
`default_nettype none
module scmc_peer (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic       ch,
  input  wire logic       bad,
  input  wire logic       slow,
  output logic      [1:0] done,
  output logic      [1:0] err
);
  int n = -1;
  initial
  begin
    done = 2'h0;
    err = 2'h0;
  end
  always @(posedge core_clk)
  begin
    done <= 2'h0;
    err <= 2'h0;
    if (go)
      n <= slow ? 9 : 1;
    else if (n > 0)
      n <= n - 1;
    else if (n == 0)
    begin
      n <= -1;
      done[ch] <= 1'b1;
      err[ch] <= bad;
    end
  end
endmodule
`default_nettype wire

// *** test/scmc_top_bench.sv ***
// Purpose: Self-checking bench for the configuration bank
// Assumes: Inputs move 1 ns after the rising edge
// Notes:   Tasks t_reset through t_run are one scenario each; the rest are helpers
`timescale 1ns/1ns
`default_nettype none
`include "scmc_params.svh"
module scmc_top_bench;
  logic                      core_clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic [19:0]               reg_addr = 20'h0_0000;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic [7:0]                reg_wdata = 8'h00;
  logic [1:0]                run = 2'h0;
  logic                      go = 1'b0;
  logic                      pch = 1'b0;
  logic                      bad = 1'b0;
  logic                      slow = 1'b0;
  logic [1:0]                done;
  logic [1:0]                err;
  logic [7:0]                rdata;
  logic                      rvalid;
  scmc_pkg::scmc_cfg_t [1:0] cfg;
  logic [1:0]                eirq;
  logic [1:0]                rirq;
  logic [1:0]                wflag;
  int                        fail_count = 0;
  int                        total_checks = 0;
  always #20 core_clk = ~core_clk;
  scmc_top #(.NCH(2)) DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .channel_running_flag(run),
    .rx_error_event(err), .rx_done_event(done), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .chan_cfg(cfg), .error_interrupt(eirq), .receive_end_interrupt(rirq),
    .cfg_write_while_running(wflag));
  scmc_peer peer (.core_clk(core_clk), .go(go), .ch(pch), .bad(bad), .slow(slow),
    .done(done), .err(err));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    tick();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e, input string nm);
    tick();
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    chb("rvalid", 1'b1, rvalid);
    chk(nm, e, rdata);
  endtask
  task automatic t_reset;
    rd(`SCMC_MODE_LOW_CH0, 8'h20, "mode0");
    rd(`SCMC_MODE_LOW_CH1, 8'h20, "mode1");
    rd(`SCMC_COMM_LOW_CH0, 8'h87, "clo0");
    rd(`SCMC_COMM_HIGH_CH0, 8'h00, "chi0");
    rd(`SCMC_COMM_LOW_CH1, 8'h87, "clo1");
    rd(`SCMC_COMM_HIGH_CH1, 8'h00, "chi1");
    rd(20'h0_0000, 8'h00, "unmapped");
    chk("xfer", 8'h01, {4'h0, cfg[0].xfer});
  endtask
  task automatic t_mode;
    wr(`SCMC_MODE_LOW_CH0, 8'hff);
    rd(`SCMC_MODE_LOW_CH0, 8'h23, "mode0 mask");
    wr(`SCMC_MODE_LOW_CH1, 8'hff);
    rd(`SCMC_MODE_LOW_CH1, 8'h63, "mode1 mask");
    chb("uart", 1'b1, cfg[1].uart_mode);
    chb("bufe", 1'b1, cfg[1].buf_empty_irq);
    chb("rxinv", 1'b1, cfg[1].rx_level_invert);
    chb("rxinv0", 1'b0, cfg[0].rx_level_invert);
    wr(`SCMC_MODE_LOW_CH1, 8'h00);
    rd(`SCMC_MODE_LOW_CH1, 8'h20, "mode1 clr");
    chb("csi", 1'b0, cfg[1].uart_mode);
    chb("xend", 1'b0, cfg[1].buf_empty_irq);
  endtask
  task automatic t_low;
    wr(`SCMC_COMM_LOW_CH0, 8'hff);
    rd(`SCMC_COMM_LOW_CH0, 8'hb7, "clo0 mask");
    chb("stop bad", 1'b1, cfg[0].stop_illegal);
    wr(`SCMC_COMM_LOW_CH1, 8'hff);
    rd(`SCMC_COMM_LOW_CH1, 8'h97, "clo1 mask");
    chk("stop1", 8'h01, {6'h00, cfg[1].stop_bits});
    wr(`SCMC_COMM_LOW_CH0, 8'h20);
    rd(`SCMC_COMM_LOW_CH0, 8'h26, "clo0 fix");
    chk("stop2", 8'h02, {6'h00, cfg[0].stop_bits});
    chb("lsb", 1'b0, cfg[0].lsb_first);
    chb("len8", 1'b0, cfg[0].data_8bit);
    chb("lsb1", 1'b1, cfg[1].lsb_first);
    chb("len81", 1'b1, cfg[1].data_8bit);
  endtask
  task automatic t_high;
    logic [7:0] d;
    for (int k = 0; k < 4; k++)
    begin
      d = {k[1:0], k[1:0], 2'h0, k[1:0]};
      wr(`SCMC_COMM_HIGH_CH1, d);
      rd(`SCMC_COMM_HIGH_CH1, d, "chi1");
      chk("xfer", 8'h01 << k, {4'h0, cfg[1].xfer});
      chk("phase", 8'(k + 1), {5'h00, cfg[1].phase_type});
      chk("parity", 8'h01 << k, {4'h0, cfg[1].parity});
    end
    // Channel 0 high byte: bit 3 is not writable, so it reads back clear
    wr(`SCMC_COMM_HIGH_CH0, 8'hcf);
    rd(`SCMC_COMM_HIGH_CH0, 8'hc7, "chi0 mask");
  endtask
  task automatic frame(input int c, input logic b, input logic s, input logic e,
                       input logic r);
    int i;
    pch = c[0];
    bad = b;
    slow = s;
    go = 1'b1;
    tick();
    go = 1'b0;
    for (i = 0; i < 20 && done[c] !== 1'b1; i++)
      tick();
    if (i == 20)
    begin
      chk("peer wait", 8'h01, 8'h00);
      tally_and_finish();
    end
    tick();
    chb("err irq", e, eirq[c]);
    chb("end irq", r, rirq[c]);
  endtask
  task automatic t_irq;
    chb("eoc on", 1'b1, cfg[0].error_irq_enable);
    frame(0, 1'b1, 1'b0, 1'b1, 1'b0);
    frame(0, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(`SCMC_COMM_HIGH_CH0, 8'h00);
    tick();
    chb("eoc off", 1'b0, cfg[0].error_irq_enable);
    frame(0, 1'b1, 1'b1, 1'b0, 1'b1);
    frame(1, 1'b1, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_run;
    run = 2'h1;
    wr(`SCMC_COMM_LOW_CH0, 8'h87);
    chk("run flag0", 8'h01, {6'h00, wflag});
    run = 2'h2;
    wr(`SCMC_COMM_HIGH_CH1, 8'h00);
    chk("run flag1", 8'h02, {6'h00, wflag});
    run = 2'h0;
    rd(`SCMC_COMM_HIGH_CH1, 8'h00, "run write");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_mode();
    t_low();
    t_high();
    t_irq();
    t_run();
    tally_and_finish();
  end
endmodule
bind scmc_top scmc_checker #(.NCH(NCH)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .channel_running_flag(channel_running_flag), .rx_error_event(rx_error_event),
  .rx_done_event(rx_done_event), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .chan_cfg(chan_cfg), .error_interrupt(error_interrupt),
  .receive_end_interrupt(receive_end_interrupt),
  .cfg_write_while_running(cfg_write_while_running));
`default_nettype wire
